// ==== design/tcdma_regs.vh ====
// Constants for the two channel DMA controller
`ifndef TCDMA_REGS_VH
`define TCDMA_REGS_VH

// ==========================================
// Engine states
`define TCDMA_ST_IDLE 1'b0
`define TCDMA_ST_BURST 1'b1

// ==========================================
// Trigger source select codes
`define TCDMA_TRIG_SW 2'h0
`define TCDMA_TRIG_PERIPH 2'h1
`define TCDMA_TRIG_EVENT 2'h2

// ==========================================
// Address step modes
`define TCDMA_AM_FIXED 2'h0
`define TCDMA_AM_INC 2'h1
`define TCDMA_AM_DEC 2'h2

// ==========================================
// Address reload points
`define TCDMA_RLD_NONE 2'h0
`define TCDMA_RLD_BURST 2'h1
`define TCDMA_RLD_BLOCK 2'h2
`define TCDMA_RLD_TXN 2'h3

// ==========================================
// Burst length codes (1, 2, 4, 8 bytes)
`define TCDMA_BL_1 2'h0
`define TCDMA_BL_2 2'h1
`define TCDMA_BL_4 2'h2
`define TCDMA_BL_8 2'h3

// ==========================================
// Memory mapped EEPROM window in data space
`define TCDMA_EE_BASE 16'h1000
`define TCDMA_EE_LAST 16'h17ff

// ==========================================
// Counter widths and constants
`define TCDMA_BLK_FULL 17'h10000
`define TCDMA_REP_FULL 9'h100
`define TCDMA_ADDR_ZERO 16'h0000
`define TCDMA_ADDR_ONE 16'h0001

`endif

// ==== design/tcdma_chan.v ====
// Per-channel address and byte counting unit
`timescale 1ns/100ps
`include "tcdma_regs.vh"

module tcdma_chan (
  input wire sys_clk, // System clock
  input wire nrst, // Async reset, active low
  input wire load, // Load start values
  input wire step, // One byte read issued
  input wire [1:0] burst_sel, // Burst length code
  input wire [15:0] blk_size, // Block bytes, 0 means 64 KB
  input wire [7:0] rep_cnt, // Blocks per transaction, 0 means 256
  input wire [15:0] src_start, // Source start address
  input wire [15:0] dst_start, // Destination start address
  input wire [1:0] src_mode, // Source step mode
  input wire [1:0] dst_mode, // Destination step mode
  input wire [1:0] src_rld, // Source reload point
  input wire [1:0] dst_rld, // Destination reload point
  output wire [15:0] src_addr, // Current source address
  output wire [15:0] dst_addr, // Current destination address
  output wire burst_last, // Next byte closes a burst
  output wire txn_last // Next byte closes the transaction
);

  reg [15:0] src_q, src_d; // Source pointer
  reg [15:0] dst_q, dst_d; // Destination pointer
  reg [16:0] bcnt_q, bcnt_d; // Bytes left in block
  reg [3:0] burst_q, burst_d; // Bytes left in burst
  reg [8:0] rep_q, rep_d; // Blocks left
  reg [3:0] blen; // Burst length in bytes
  wire [16:0] blk_init; // Block size reload value
  wire [8:0] rep_init; // Repeat reload value
  wire blk_last; // Next byte closes a block

  assign blk_init = (blk_size == `TCDMA_ADDR_ZERO) ? `TCDMA_BLK_FULL : {1'b0, blk_size};
  assign rep_init = (rep_cnt == 8'h00) ? `TCDMA_REP_FULL : {1'b0, rep_cnt};
  assign blk_last = (bcnt_q == 17'h00001);
  assign burst_last = (burst_q == 4'h1) || blk_last;
  assign txn_last = blk_last && (rep_q == 9'h001);
  assign src_addr = src_q;
  assign dst_addr = dst_q;

  // ==========================================
  // Burst length decode
  always @* begin
    case (burst_sel)
      `TCDMA_BL_1: blen = 4'h1;
      `TCDMA_BL_2: blen = 4'h2;
      `TCDMA_BL_4: blen = 4'h4;
      default: blen = 4'h8;
    endcase
  end

  // Next address for a pointer after one byte
  function [15:0] next_addr;
    input [15:0] cur;
    input [1:0] mode;
    input [1:0] rld;
    input [15:0] start;
    input b_end;
    input k_end;
    input t_end;
    begin
      if ((rld == `TCDMA_RLD_BURST && b_end) || (rld == `TCDMA_RLD_BLOCK && k_end) ||
          (rld == `TCDMA_RLD_TXN && t_end)) begin
        next_addr = start;
      end else if (mode == `TCDMA_AM_INC) begin
        next_addr = cur + `TCDMA_ADDR_ONE;
      end else if (mode == `TCDMA_AM_DEC) begin
        next_addr = cur - `TCDMA_ADDR_ONE;
      end else begin
        next_addr = cur;
      end
    end
  endfunction

  // ==========================================
  // Counter and pointer update
  always @* begin
    src_d = src_q;
    dst_d = dst_q;
    bcnt_d = bcnt_q;
    burst_d = burst_q;
    rep_d = rep_q;
    if (load) begin
      src_d = src_start;
      dst_d = dst_start;
      bcnt_d = blk_init;
      burst_d = blen;
      rep_d = rep_init;
    end else if (step) begin
      src_d = next_addr(src_q, src_mode, src_rld, src_start, burst_last, blk_last, txn_last);
      dst_d = next_addr(dst_q, dst_mode, dst_rld, dst_start, burst_last, blk_last, txn_last);
      if (blk_last) begin
        // Block done: rerun it while repeats remain
        bcnt_d = blk_init;
        rep_d = rep_q - 9'h001;
        burst_d = blen;
      end else begin
        bcnt_d = bcnt_q - 17'h00001;
        burst_d = burst_last ? blen : burst_q - 4'h1;
      end
    end
  end

  // Registers
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      bcnt_q <= 17'h00001;
      burst_q <= 4'h1;
      rep_q <= 9'h001;
    end else begin
      src_q <= src_d;
      dst_q <= dst_d;
      bcnt_q <= bcnt_d;
      burst_q <= burst_d;
      rep_q <= rep_d;
    end
  end

endmodule // tcdma_chan

// ==== design/tcdma_top.v ====
// Two channel DMA controller: trigger, arbitration and data path
// How it works
// - Two channels with independent settings.
// - Bursts of one, two, four, eight bytes.
// - Block size from one byte to 64 KB.
// - Repeat counter reruns block, up to 16 MB.
// - Addresses fixed, incrementing or decrementing.
// - Address reload at burst, block or transaction.
// - Software, peripheral or event trigger starts transfer.
// - Done and error interrupts, each with enable.
// - Chaining hands over to other channel.
// - EEPROM window usable as read source.
// - Moved bytes optionally fed to CRC.
// - SRAM byte per cycle, EEPROM every second.
// - Separate read and write bus masters.
`timescale 1ns/100ps
`include "tcdma_regs.vh"

module tcdma_top (
  input wire sys_clk, // System clock, 250 MHz
  input wire nrst, // Async reset, active low
  input wire [1:0] ch_start, // Arm channel, one pulse per channel
  input wire [3:0] ch_burst_sel, // Burst code, ch1 in [3:2]
  input wire [31:0] ch_blk_size, // Block size, ch1 in [31:16]
  input wire [15:0] ch_rep_cnt, // Repeat count, ch1 in [15:8]
  input wire [31:0] ch_src_start, // Source start, ch1 in [31:16]
  input wire [31:0] ch_dst_start, // Destination start, ch1 in [31:16]
  input wire [3:0] ch_src_mode, // Source step mode per channel
  input wire [3:0] ch_dst_mode, // Destination step mode per channel
  input wire [3:0] ch_src_rld, // Source reload point per channel
  input wire [3:0] ch_dst_rld, // Destination reload point per channel
  input wire [3:0] ch_trig_sel, // Trigger source per channel
  input wire [1:0] ch_sw_trig, // Software trigger pulses
  input wire [1:0] ch_periph_req, // Peripheral request pulses
  input wire [1:0] ch_evt, // Event channel pulses
  input wire [1:0] ch_done_ie, // Done interrupt enables
  input wire [1:0] ch_err_ie, // Error interrupt enables
  input wire [1:0] ch_done_clr, // Clear done flags
  input wire [1:0] ch_err_clr, // Clear error flags
  input wire [1:0] ch_chain, // Hand over to other channel on done
  input wire [1:0] ch_crc_en, // Route channel data to CRC
  input wire prio_rr, // 1 round robin, 0 channel 0 first
  output wire [1:0] ch_busy, // Channel armed and not finished
  output wire [1:0] ch_done, // Sticky done flags
  output wire [1:0] ch_err, // Sticky error flags
  output wire [1:0] ch_done_irq, // Done interrupt requests
  output wire [1:0] ch_err_irq, // Error interrupt requests
  output wire rd_en, // Read master strobe
  output wire [15:0] rd_addr, // Read master address
  input wire [7:0] rd_data, // Read data, cycle after rd_en
  input wire rd_err, // Read error, with rd_data
  output wire wr_en, // Write master strobe
  output wire [15:0] wr_addr, // Write master address
  output wire [7:0] wr_data, // Write master data
  input wire wr_err, // Write error, same cycle as wr_en
  output wire crc_valid, // Byte for checksum generator
  output wire [7:0] crc_data // Checksum input byte
);

  reg state_q, state_d; // Engine state
  reg gnt_q, gnt_d; // Granted channel
  reg last_q, last_d; // Last served channel, round robin
  reg pace_q, pace_d; // EEPROM pacing phase
  reg [1:0] busy_q, busy_d; // Channel armed
  reg [1:0] pend_q, pend_d; // Trigger pending
  reg [1:0] done_q, done_d; // Sticky done
  reg [1:0] err_q, err_d; // Sticky error
  reg b1_v_q; // Read beat in flight
  reg b1_ch_q; // Channel of beat in flight
  reg b1_crc_q; // Beat goes to CRC
  reg [15:0] b1_dst_q; // Destination of beat in flight
  reg wr_en_q; // Write strobe
  reg wr_ch_q; // Channel of write
  reg [15:0] wr_addr_q; // Write address
  reg [7:0] wr_data_q; // Write data
  reg crc_v_q; // CRC strobe
  reg [7:0] crc_d_q; // CRC byte
  reg [1:0] trig; // Selected trigger per channel
  reg [1:0] abort; // Error abort per channel
  reg [1:0] load; // Channel counter loads
  reg [1:0] step; // Byte issued per channel
  reg issue; // Read issued this cycle
  reg pick; // Arbiter choice
  wire [31:0] src_all; // Source addresses
  wire [31:0] dst_all; // Destination addresses
  wire [1:0] blast; // Burst end flags
  wire [1:0] tlast; // Transaction end flags
  wire [1:0] ready; // Channels able to start a burst
  wire [15:0] cur_src; // Granted source
  wire src_ee; // Granted source lies in EEPROM window

  // ==========================================
  // Channel units
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      tcdma_chan tcdma_chan_i (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(load[gi]),
        .step(step[gi]),
        .burst_sel(ch_burst_sel[2*gi+1:2*gi]),
        .blk_size(ch_blk_size[16*gi+15:16*gi]),
        .rep_cnt(ch_rep_cnt[8*gi+7:8*gi]),
        .src_start(ch_src_start[16*gi+15:16*gi]),
        .dst_start(ch_dst_start[16*gi+15:16*gi]),
        .src_mode(ch_src_mode[2*gi+1:2*gi]),
        .dst_mode(ch_dst_mode[2*gi+1:2*gi]),
        .src_rld(ch_src_rld[2*gi+1:2*gi]),
        .dst_rld(ch_dst_rld[2*gi+1:2*gi]),
        .src_addr(src_all[16*gi+15:16*gi]),
        .dst_addr(dst_all[16*gi+15:16*gi]),
        .burst_last(blast[gi]),
        .txn_last(tlast[gi])
      );
    end
  endgenerate

  assign cur_src = gnt_q ? src_all[31:16] : src_all[15:0];
  assign src_ee = (cur_src >= `TCDMA_EE_BASE) && (cur_src <= `TCDMA_EE_LAST);
  assign ready = busy_q & pend_q & ~abort;

  // ==========================================
  // Trigger select and error detect
  always @* begin : p_trig
    integer i;
    trig = 2'b00;
    for (i = 0; i < 2; i = i + 1) begin
      case (ch_trig_sel[2*i+:2])
        `TCDMA_TRIG_SW: trig[i] = ch_sw_trig[i];
        `TCDMA_TRIG_PERIPH: trig[i] = ch_periph_req[i];
        `TCDMA_TRIG_EVENT: trig[i] = ch_evt[i];
        default: trig[i] = 1'b0;
      endcase
    end
    abort = 2'b00;
    if (b1_v_q && rd_err) begin
      abort[b1_ch_q] = 1'b1;
    end
    if (wr_en_q && wr_err) begin
      abort[wr_ch_q] = 1'b1;
    end
  end

  // ==========================================
  // Arbiter: round robin or fixed channel 0 first
  always @* begin
    if (ready == 2'b11) begin
      pick = prio_rr ? ~last_q : 1'b0;
    end else begin
      pick = ready[1] & ~ready[0];
    end
  end

  // ==========================================
  // Engine state machine
  always @* begin
    state_d = state_q;
    gnt_d = gnt_q;
    last_d = last_q;
    pace_d = pace_q;
    busy_d = (busy_q | ch_start) & ~abort;
    pend_d = pend_q;
    done_d = done_q & ~ch_done_clr;
    err_d = (err_q & ~ch_err_clr) | abort;
    load = ch_start;
    step = 2'b00;
    issue = 1'b0;
    case (state_q)
      `TCDMA_ST_IDLE: begin
        if (ready != 2'b00) begin
          // Grant is held until the burst finishes
          state_d = `TCDMA_ST_BURST;
          gnt_d = pick;
          last_d = pick;
          pace_d = 1'b0;
          pend_d[pick] = 1'b0;
        end
      end
      default: begin
        if (abort[gnt_q] || !busy_q[gnt_q]) begin
          state_d = `TCDMA_ST_IDLE;
        end else begin
          // EEPROM source gives a byte every second cycle
          issue = !src_ee || !pace_q;
          pace_d = src_ee ? ~pace_q : 1'b0;
          step[gnt_q] = issue;
          if (issue && blast[gnt_q]) begin
            state_d = `TCDMA_ST_IDLE;
            if (tlast[gnt_q]) begin
              busy_d[gnt_q] = 1'b0;
              done_d[gnt_q] = 1'b1;
              if (ch_chain[gnt_q]) begin
                // Other channel is rearmed with no gap
                load[~gnt_q] = 1'b1;
                busy_d[~gnt_q] = 1'b1;
              end
            end
          end
        end
      end
    endcase
    // A new trigger beats the clear of its pending flag
    pend_d = (pend_d | (trig & busy_q)) & busy_d;
  end

  // State registers
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= `TCDMA_ST_IDLE;
      gnt_q <= 1'b0;
      last_q <= 1'b1;
      pace_q <= 1'b0;
      busy_q <= 2'b00;
      pend_q <= 2'b00;
      done_q <= 2'b00;
      err_q <= 2'b00;
    end else begin
      state_q <= state_d;
      gnt_q <= gnt_d;
      last_q <= last_d;
      pace_q <= pace_d;
      busy_q <= busy_d;
      pend_q <= pend_d;
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  // ==========================================
  // Data path: read beat then write beat
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      b1_v_q <= 1'b0;
      b1_ch_q <= 1'b0;
      b1_crc_q <= 1'b0;
      b1_dst_q <= 16'h0000;
      wr_en_q <= 1'b0;
      wr_ch_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 8'h00;
      crc_v_q <= 1'b0;
      crc_d_q <= 8'h00;
    end else begin
      b1_v_q <= issue;
      b1_ch_q <= gnt_q;
      b1_crc_q <= ch_crc_en[gnt_q];
      b1_dst_q <= gnt_q ? dst_all[31:16] : dst_all[15:0];
      // Write side runs as its own master, one cycle behind the read
      wr_en_q <= b1_v_q && !rd_err;
      wr_ch_q <= b1_ch_q;
      if (b1_v_q) begin
        wr_addr_q <= b1_dst_q;
        wr_data_q <= rd_data;
        crc_d_q <= rd_data;
      end
      crc_v_q <= b1_v_q && !rd_err && b1_crc_q;
    end
  end

  // ==========================================
  // Outputs
  assign rd_en = issue;
  assign rd_addr = cur_src;
  assign wr_en = wr_en_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign crc_valid = crc_v_q;
  assign crc_data = crc_d_q;
  assign ch_busy = busy_q;
  assign ch_done = done_q;
  assign ch_err = err_q;
  assign ch_done_irq = done_q & ch_done_ie;
  assign ch_err_irq = err_q & ch_err_ie;

endmodule // tcdma_top

// ==== verif/tcdma_checker.sv ====
// Assertion checker for the two channel DMA top
`timescale 1ns/100ps
`include "tcdma_regs.vh"

module tcdma_checker (
  input wire sys_clk, // Clock
  input wire nrst, // Reset, active low
  input wire [1:0] ch_start, // Arm pulses
  input wire [1:0] ch_done_ie, // Done enables
  input wire [1:0] ch_err_ie, // Error enables
  input wire [1:0] ch_done_clr, // Done clears
  input wire [1:0] ch_busy, // Busy flags
  input wire [1:0] ch_done, // Done flags
  input wire [1:0] ch_err, // Error flags
  input wire [1:0] ch_done_irq, // Done requests
  input wire [1:0] ch_err_irq, // Error requests
  input wire rd_en, // Read strobe
  input wire [15:0] rd_addr, // Read address
  input wire rd_err, // Read fault
  input wire wr_en, // Write strobe
  input wire [7:0] wr_data, // Write byte
  input wire crc_valid, // Checksum strobe
  input wire [7:0] crc_data // Checksum byte
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [4:0] run_q; // Length of the current read run
  // ==========================================
  // Counts back to back read strobes
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 5'h00;
    end else begin
      run_q <= rd_en ? run_q + 5'h01 : 5'h00;
    end
  end
  // ==========================================
  // Properties
  a_burst_len: assert property (run_q <= 5'h08)
    else $error("read run longer than eight");
  a_ee_gap: assert property (rd_en && rd_addr >= `TCDMA_EE_BASE && rd_addr <= `TCDMA_EE_LAST |=> !rd_en)
    else $error("window reads not spaced");
  a_wr_follow: assert property (rd_en ##1 !rd_err |-> ##1 wr_en)
    else $error("write missing after read");
  a_crc_pair: assert property (crc_valid |-> wr_en && crc_data == wr_data)
    else $error("checksum byte differs from write");
  a_done_irq: assert property (ch_done_irq == (ch_done & ch_done_ie))
    else $error("done request not flag and enable");
  a_err_irq: assert property (ch_err_irq == (ch_err & ch_err_ie))
    else $error("error request not flag and enable");
  a_busy_start: assert property (ch_start[0] |=> ch_busy[0])
    else $error("start did not arm channel");
  a_done_hold: assert property (ch_done[0] && !ch_done_clr[0] |=> ch_done[0])
    else $error("done flag lost");
  a_done_end: assert property ($rose(ch_done[0]) |-> $fell(ch_busy[0]))
    else $error("done without end of busy");
  a_read_busy: assert property (rd_en |-> ch_busy != 2'h0)
    else $error("read while no channel armed");
  c_crc: cover property (crc_valid);
  c_done: cover property ($rose(ch_done[1]));
  c_err: cover property ($rose(ch_err[1]));
endmodule // tcdma_checker

bind tcdma_top tcdma_checker tcdma_checker_i (.sys_clk, .nrst, .ch_start, .ch_done_ie, .ch_err_ie,
  .ch_done_clr, .ch_busy, .ch_done, .ch_err, .ch_done_irq, .ch_err_irq, .rd_en, .rd_addr, .rd_err,
  .wr_en, .wr_data, .crc_valid, .crc_data);

// ==== verif/tcdma_mem.sv ====
// Memory and register partner on the read and write masters
`timescale 1ns/100ps

module tcdma_mem (
  input wire sys_clk, // Clock
  input wire rd_en, // Read strobe
  input wire [15:0] rd_addr, // Read address
  input wire wr_en, // Write strobe
  input wire [15:0] wr_addr, // Write address
  input wire [15:0] err_addr, // Address that faults
  output logic [7:0] rd_data = 8'h00, // Read byte
  output logic rd_err = 1'b0, // Read fault
  output wire wr_err // Write fault
);
  // ==========================================
  // Byte the cycle after the strobe, else toggling
  always @(posedge sys_clk) begin
    rd_data <= rd_en ? (rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h5a) : ~rd_data;
    rd_err <= rd_en && rd_addr == err_addr;
  end
  // Write fault in the strobe cycle
  assign wr_err = wr_en && wr_addr == err_addr;
endmodule // tcdma_mem

// ==== verif/two_channel_dma_controller_bench.sv ====
// Self-checking bench for the two channel DMA top
`timescale 1ns/100ps

module two_channel_dma_controller_bench;
  logic sys_clk = 1'b0, nrst = 1'b0, prio_rr = 1'b0;
  logic [1:0] ch_start = '0, ch_sw_trig = '0, ch_periph_req = '0, ch_evt = '0, ch_done_ie = '0;
  logic [1:0] ch_err_ie = '0, ch_done_clr = '0, ch_err_clr = '0, ch_chain = '0, ch_crc_en = '0;
  logic [3:0] ch_burst_sel = '0, ch_src_mode = '0, ch_dst_mode = '0, ch_src_rld = '0, ch_dst_rld = '0;
  logic [3:0] ch_trig_sel = '0;
  logic [31:0] ch_blk_size = '0, ch_src_start = '0, ch_dst_start = '0;
  logic [15:0] ch_rep_cnt = '0, err_addr = 16'hffff;
  wire [1:0] ch_busy, ch_done, ch_err, ch_done_irq, ch_err_irq;
  wire rd_en, wr_en, rd_err, wr_err, crc_valid;
  wire [15:0] rd_addr, wr_addr;
  wire [7:0] rd_data, wr_data, crc_data;
  int fail_count = 0, num_checks = 0, cyc = 0, seed = 32'h7bba2092;
  bit skip = 1'b0; // Writes not modelled
  int exq[$]; // Expected writes, address and byte
  tcdma_top tcdma_top_i (.sys_clk, .nrst, .ch_start, .ch_burst_sel, .ch_blk_size, .ch_rep_cnt,
    .ch_src_start, .ch_dst_start, .ch_src_mode, .ch_dst_mode, .ch_src_rld, .ch_dst_rld, .ch_trig_sel,
    .ch_sw_trig, .ch_periph_req, .ch_evt, .ch_done_ie, .ch_err_ie, .ch_done_clr, .ch_err_clr, .ch_chain,
    .ch_crc_en, .prio_rr, .ch_busy, .ch_done, .ch_err, .ch_done_irq, .ch_err_irq, .rd_en, .rd_addr,
    .rd_data, .rd_err, .wr_en, .wr_addr, .wr_data, .wr_err, .crc_valid, .crc_data);
  tcdma_mem tcdma_mem_i (.sys_clk, .rd_en, .rd_addr, .wr_en, .wr_addr, .err_addr, .rd_data, .rd_err,
    .wr_err);
  // ==========================================
  // Clock and hang guard
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out;
    end
  end
  // Every write against the model while skip is clear
  always @(posedge sys_clk) begin
    if (wr_en && !skip) begin
      if (exq.size() == 0) chk("wr_extra", 24'h0, 24'h1);
      else chk("wr_byte", exq.pop_front(), {wr_addr, wr_data});
    end
  end
  // ==========================================
  // Tasks
  task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Next address after one byte
  function int nx(int a, int m, int r, int st, bit be, bit ke, bit te);
    if (m == 1) a = a + 1;
    else if (m == 2) a = a - 1;
    if ((r == 1 && be) || (r == 2 && ke) || (r == 3 && te)) a = st;
    return a & 16'hffff;
  endfunction
  // Expected writes of one transaction
  task gen(input int c);
    int bl, blk, tot, s, d, p, k, n;
    bit be, ke, te;
    bl = 1 << ch_burst_sel[c*2+:2];
    blk = ch_blk_size[c*16+:16];
    tot = blk * ch_rep_cnt[c*8+:8];
    s = ch_src_start[c*16+:16];
    d = ch_dst_start[c*16+:16];
    p = 0;
    k = 0;
    for (n = 0; n < tot; n++) begin
      exq.push_back((d << 8) | ((s & 8'hff) ^ (s >> 8) ^ 8'h5a));
      ke = k == blk - 1;
      be = ke || p == bl - 1;
      te = n == tot - 1;
      s = nx(s, ch_src_mode[c*2+:2], ch_src_rld[c*2+:2], ch_src_start[c*16+:16], be, ke, te);
      d = nx(d, ch_dst_mode[c*2+:2], ch_dst_rld[c*2+:2], ch_dst_start[c*16+:16], be, ke, te);
      p = be ? 0 : p + 1;
      k = ke ? 0 : k + 1;
    end
  endtask
  task cfg(input int c, b, k, r, ss, sm, sr, ds, dm, dr, tg);
    @(posedge sys_clk);
    ch_burst_sel[c*2+:2] <= 2'(b);
    ch_blk_size[c*16+:16] <= 16'(k);
    ch_rep_cnt[c*8+:8] <= 8'(r);
    ch_src_start[c*16+:16] <= 16'(ss);
    ch_src_mode[c*2+:2] <= 2'(sm);
    ch_src_rld[c*2+:2] <= 2'(sr);
    ch_dst_start[c*16+:16] <= 16'(ds);
    ch_dst_mode[c*2+:2] <= 2'(dm);
    ch_dst_rld[c*2+:2] <= 2'(dr);
    ch_trig_sel[c*2+:2] <= 2'(tg);
  endtask
  // Arm, hold the trigger until the channel finishes
  task run(input int c, input int tg);
    int i;
    @(posedge sys_clk);
    if (!skip) begin
      gen(c);
      // A chained partner runs right after, so its bytes queue behind
      if (ch_chain[c]) gen(1 - c);
    end
    ch_start[c] <= 1'b1;
    @(posedge sys_clk);
    ch_start[c] <= 1'b0;
    if (tg == 0) ch_sw_trig[c] <= 1'b1;
    else if (tg == 1) ch_periph_req[c] <= 1'b1;
    else ch_evt[c] <= 1'b1;
    @(posedge sys_clk);
    #1 chk("busy", 24'h1, ch_busy[c]);
    // Busy is looked at off the edge; a chained partner extends the wait
    for (i = 0; i < 3000 && (ch_busy[c] || (ch_chain[c] && ch_busy[1 - c])); i++) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    ch_sw_trig <= '0;
    ch_periph_req <= '0;
    ch_evt <= '0;
    repeat (5) @(posedge sys_clk);
    #1 chk("left", 24'h0, exq.size());
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    ch_done_ie <= 2'h1;
    ch_crc_en <= 2'h1;
    prio_rr <= 1'($random(seed));
    cfg(0, 1, 5, 2, 16'h0200, 1, 0, 16'h2000 | ($random(seed) & 16'h0fff), 1, 2, 0);
    run(0, 0);
    chk("done0", 24'h1, ch_done[0]);
    chk("irq0", 24'h1, ch_done_irq[0]);
    @(posedge sys_clk);
    ch_done_ie <= 2'h0;
    ch_done_clr <= 2'h1;
    @(posedge sys_clk);
    ch_done_clr <= 2'h0;
    #1 chk("clr0", 24'h0, {ch_done[0], ch_done_irq[0]});
    cfg(1, 3, 3, 1, 16'h1010, 2, 1, 16'h0300, 0, 0, 1);
    run(1, 1);
    chk("done1", 24'h2, {ch_done[1], ch_done_irq[1]});
    cfg(0, 2, 4, 3, 16'h0050, 0, 0, 16'h0400, 2, 3, 2);
    run(0, 2);
    skip = 1'b1;
    err_addr <= 16'h0602;
    ch_err_ie <= 2'h2;
    cfg(1, 2, 8, 1, 16'h0600, 1, 0, 16'h0700, 1, 0, 0);
    run(1, 0);
    chk("err1", 24'h6, {ch_err[1], ch_err_irq[1], ch_busy[1]});
    @(posedge sys_clk);
    ch_err_clr <= 2'h2;
    ch_done_clr <= 2'h3;
    @(posedge sys_clk);
    ch_err_clr <= 2'h0;
    ch_done_clr <= 2'h0;
    #1 chk("eclr", 24'h0, {ch_err[1], ch_done});
    // Chain: channel 1 is only armed by the end of channel 0
    skip = 1'b0;
    err_addr <= 16'hffff;
    ch_chain <= 2'h1;
    ch_sw_trig[1] <= 1'b1;
    cfg(0, 0, 3, 1, 16'h0100, 1, 0, 16'h0900, 1, 0, 0);
    cfg(1, 1, 4, 1, 16'h0700, 1, 0, 16'h0800, 1, 0, 0);
    run(0, 0);
    chk("chain", 24'h3, ch_done);
    close_out;
  end
endmodule // two_channel_dma_controller_bench
